//--- src/servo_io_monitor_feedback_counter.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Feedforward gain 0 to 1.0000, reset 1.0000; gain zero turns feedforward off.
// - Input monitors show the line after polarity inversion and debounce timer.
// - Output monitors show internal state before settle timer and logic sense.
// - Hold monitor reads 1 while conditioned hold input is active, else 0.
// - Integrator-disable monitor reads 1 while conditioned input requests it, else 0.
// - In-place monitor reads 1 when positioning done and target held.
// - Manual-move monitor reads 1 for acceleration start, 0 for deceleration.
// - Feedback counter counts each edge of either quadrature phase; edges of both phases in one cycle are not counted.
// - Feedback counter is signed 32-bit; writing zero clears it.
// - Proximity-A monitor reads 1 when nearing final target, else 0.
// - Proximity-B monitor reads 1 independently when nearing final target.
// - Healthy monitor reads 1 when no alarm or warning is present.
// - Torque filters bypassed at or below threshold speed; zero threshold never bypasses.
// - Bypass acts on both primary and secondary torque filter stages.
// - Override monitor reads 1 while conditioned override input is active.
// - Minus-limit monitor reads 1 when conditioned limit input detects limit.
module servo_io_monitor_feedback_counter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic hold_input,
    input wire logic integrator_disable_input,
    input wire logic manual_move_input,
    input wire logic speed_override_input,
    input wire logic minus_limit_input,
    input wire logic in_place_state,
    input wire logic proximity_a_state,
    input wire logic proximity_b_state,
    input wire logic healthy_state,
    output logic in_place_output,
    output logic proximity_a_output,
    output logic proximity_b_output,
    output logic healthy_output,
    input wire logic feedback_phase_a,
    input wire logic feedback_phase_b,
    input wire logic [13:0] motor_speed,
    output logic [13:0] forward_term_gain,
    output logic feedforward_enable,
    output logic primary_torque_lpf_bypass,
    output logic secondary_torque_lpf_bypass
);

    typedef struct packed {
        logic [servo_mon_pkg::GAIN_W-1:0] gain;
        logic [servo_mon_pkg::SPEED_W-1:0] thr;
        logic [servo_mon_pkg::N_IN-1:0] pol;
        logic [servo_mon_pkg::TMR_W-1:0] db_tmr;
        logic [servo_mon_pkg::TMR_W-1:0] settle_tmr;
        logic [servo_mon_pkg::N_OUT-1:0] sense;
        logic [servo_mon_pkg::N_IN-1:0] in_mon;
        logic [servo_mon_pkg::N_IN-1:0][servo_mon_pkg::TMR_W-1:0] db_cnt;
        logic [servo_mon_pkg::N_OUT-1:0] out_mon;
        logic [servo_mon_pkg::TMR_W-1:0] settle_cnt;
        logic [servo_mon_pkg::N_OUT-1:0] out_pin;
        logic [1:0] quad_prev;
        logic [31:0] fb_cnt;
        logic [servo_mon_pkg::N_EV-1:0] irq_sts;
        logic [servo_mon_pkg::N_EV-1:0] irq_en;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic bypass;
    } state_type;

    state_type s_r;
    state_type s_nxt;

    logic [servo_mon_pkg::N_IN-1:0] raw_in;
    logic [servo_mon_pkg::N_OUT-1:0] out_state;
    logic addr_phase;

    assign raw_in = {minus_limit_input, speed_override_input, manual_move_input,
                     integrator_disable_input, hold_input};
    assign out_state = {healthy_state, proximity_b_state, proximity_a_state, in_place_state};
    assign addr_phase = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    function automatic logic [31:0] read_mux(input state_type s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            servo_mon_pkg::OFS_FWD_GAIN: d = 32'(s.gain);
            servo_mon_pkg::OFS_BYPASS_SPEED: d = 32'(s.thr);
            servo_mon_pkg::OFS_IN_POLARITY: d = 32'(s.pol);
            servo_mon_pkg::OFS_IN_DEBOUNCE: d = 32'(s.db_tmr);
            servo_mon_pkg::OFS_OUT_SETTLE: d = 32'(s.settle_tmr);
            servo_mon_pkg::OFS_OUT_SENSE: d = 32'(s.sense);
            servo_mon_pkg::OFS_IN_MONITOR: d = 32'(s.in_mon);
            servo_mon_pkg::OFS_OUT_MONITOR: d = 32'(s.out_mon);
            servo_mon_pkg::OFS_FB_COUNTER: d = s.fb_cnt;
            servo_mon_pkg::OFS_IRQ_STATUS: d = 32'(s.irq_sts);
            servo_mon_pkg::OFS_IRQ_ENABLE: d = 32'(s.irq_en);
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [servo_mon_pkg::N_IN-1:0] tgt;
        logic [servo_mon_pkg::N_EV-1:0] ev;
        logic [servo_mon_pkg::N_EV-1:0] clr;
        logic a_chg;
        logic b_chg;
        logic [31:0] step;
        logic [31:0] base;
        s_nxt = s_r;
        tgt = raw_in ^ s_r.pol;
        ev = '0;
        clr = '0;
        base = s_r.fb_cnt;
        step = 32'h0000_0000;
        a_chg = 1'b0;
        b_chg = 1'b0;

        // Bus write, data phase
        if (s_r.wr_pend) begin
            case (s_r.wr_addr)
                servo_mon_pkg::OFS_FWD_GAIN: begin
                    if (hwdata > 32'(servo_mon_pkg::GAIN_MAX)) begin
                        s_nxt.gain = servo_mon_pkg::GAIN_MAX;
                    end else begin
                        s_nxt.gain = hwdata[servo_mon_pkg::GAIN_W-1:0];
                    end
                end
                servo_mon_pkg::OFS_BYPASS_SPEED: begin
                    if (hwdata > 32'(servo_mon_pkg::SPEED_MAX)) begin
                        s_nxt.thr = servo_mon_pkg::SPEED_MAX;
                    end else begin
                        s_nxt.thr = hwdata[servo_mon_pkg::SPEED_W-1:0];
                    end
                end
                servo_mon_pkg::OFS_IN_POLARITY: s_nxt.pol = hwdata[servo_mon_pkg::N_IN-1:0];
                servo_mon_pkg::OFS_IN_DEBOUNCE: s_nxt.db_tmr = hwdata[servo_mon_pkg::TMR_W-1:0];
                servo_mon_pkg::OFS_OUT_SETTLE: s_nxt.settle_tmr = hwdata[servo_mon_pkg::TMR_W-1:0];
                servo_mon_pkg::OFS_OUT_SENSE: s_nxt.sense = hwdata[servo_mon_pkg::N_OUT-1:0];
                servo_mon_pkg::OFS_FB_COUNTER: begin
                    if (hwdata == 32'h0000_0000) begin
                        base = 32'h0000_0000;
                    end
                end
                servo_mon_pkg::OFS_IRQ_ENABLE: s_nxt.irq_en = hwdata[servo_mon_pkg::N_EV-1:0];
                servo_mon_pkg::OFS_IRQ_CLEAR: clr = hwdata[servo_mon_pkg::N_EV-1:0];
                default: ;
            endcase
        end

        // Input conditioning: polarity then debounce
        for (int i = 0; i < servo_mon_pkg::N_IN; i++) begin
            if (tgt[i] == s_r.in_mon[i]) begin
                s_nxt.db_cnt[i] = '0;
            end else if (s_r.db_cnt[i] >= s_r.db_tmr) begin
                s_nxt.in_mon[i] = tgt[i];
                s_nxt.db_cnt[i] = '0;
            end else begin
                s_nxt.db_cnt[i] = s_r.db_cnt[i] + 1'b1;
            end
        end
        ev[servo_mon_pkg::EV_IN_CHANGE] = |(s_nxt.in_mon ^ s_r.in_mon);

        // Output monitors take the raw internal state; pins get settle and sense
        s_nxt.out_mon = out_state;
        ev[servo_mon_pkg::EV_OUT_CHANGE] = |(out_state ^ s_r.out_mon);
        if (out_state != s_r.out_mon) begin
            s_nxt.settle_cnt = '0;
        end else if (s_r.settle_cnt >= s_r.settle_tmr) begin
            s_nxt.out_pin = s_r.out_mon ^ s_r.sense;
        end else begin
            s_nxt.settle_cnt = s_r.settle_cnt + 1'b1;
        end

        // Quadrature edge counting, A leading counts up
        s_nxt.quad_prev = {feedback_phase_a, feedback_phase_b};
        a_chg = feedback_phase_a ^ s_r.quad_prev[1];
        b_chg = feedback_phase_b ^ s_r.quad_prev[0];
        if (a_chg ^ b_chg) begin
            if (feedback_phase_a ^ s_r.quad_prev[0]) begin
                step = 32'h0000_0001;
            end else begin
                step = 32'hFFFF_FFFF;
            end
        end
        ev[servo_mon_pkg::EV_QUAD_ERR] = a_chg && b_chg;
        s_nxt.fb_cnt = base + step;
        ev[servo_mon_pkg::EV_CNT_WRAP] = (step == 32'h0000_0001 && base == 32'h7FFF_FFFF)
            || (step == 32'hFFFF_FFFF && base == 32'h8000_0000);

        // Filter bypass at or below threshold speed
        s_nxt.bypass = (s_r.thr != '0) && (motor_speed <= s_r.thr);

        // Sticky status, a new event wins over a clear
        s_nxt.irq_sts = (s_r.irq_sts & ~clr) | ev;

        // Address phase: capture a snapshot for reads
        s_nxt.wr_pend = addr_phase && hwrite;
        if (addr_phase) begin
            s_nxt.wr_addr = {haddr[7:2], 2'b00};
        end
        if (addr_phase && !hwrite) begin
            s_nxt.rdata = read_mux(s_r, {haddr[7:2], 2'b00});
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.gain <= servo_mon_pkg::GAIN_RESET;
            s_r.thr <= servo_mon_pkg::SPEED_RESET;
            s_r.pol <= servo_mon_pkg::POL_RESET;
            s_r.db_tmr <= servo_mon_pkg::DEBOUNCE_RESET;
            s_r.settle_tmr <= servo_mon_pkg::SETTLE_RESET;
            s_r.sense <= servo_mon_pkg::SENSE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign irq = |(s_r.irq_sts & s_r.irq_en);
    assign in_place_output = s_r.out_pin[servo_mon_pkg::OUT_IN_PLACE];
    assign proximity_a_output = s_r.out_pin[servo_mon_pkg::OUT_PROX_A];
    assign proximity_b_output = s_r.out_pin[servo_mon_pkg::OUT_PROX_B];
    assign healthy_output = s_r.out_pin[servo_mon_pkg::OUT_HEALTHY];
    assign forward_term_gain = s_r.gain;
    assign feedforward_enable = s_r.gain != '0;
    assign primary_torque_lpf_bypass = s_r.bypass;
    assign secondary_torque_lpf_bypass = s_r.bypass;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic wr_gain_zero;
    logic wr_cnt_zero;
    assign wr_gain_zero = s_r.wr_pend && s_r.wr_addr == servo_mon_pkg::OFS_FWD_GAIN
        && hwdata == 32'h0000_0000;
    assign wr_cnt_zero = s_r.wr_pend && s_r.wr_addr == servo_mon_pkg::OFS_FB_COUNTER
        && hwdata == 32'h0000_0000;

    property p_fwd_off;
        @(posedge hclk) disable iff (!hresetn)
        wr_gain_zero |=> !feedforward_enable && forward_term_gain == '0;
    endproperty
    a_fwd_off: assert property (p_fwd_off) else $error("gain zero left feedforward on");

    property p_gain_range;
        @(posedge hclk) disable iff (!hresetn)
        forward_term_gain <= servo_mon_pkg::GAIN_MAX;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("gain above one");

    property p_debounce;
        @(posedge hclk) disable iff (!hresetn)
        $changed(s_r.in_mon[0]) |-> $past(s_r.db_cnt[0]) >= $past(s_r.db_tmr);
    endproperty
    a_debounce: assert property (p_debounce) else $error("hold changed before debounce");

    sequence s_hold_steady;
        (s_r.db_tmr == '0 && !s_r.pol[0] && !s_r.wr_pend && hold_input) [*2];
    endsequence
    property p_hold_mon;
        @(posedge hclk) disable iff (!hresetn)
        s_hold_steady |-> s_r.in_mon[servo_mon_pkg::IN_HOLD];
    endproperty
    a_hold_mon: assert property (p_hold_mon) else $error("hold monitor not set");

    property p_settle;
        @(posedge hclk) disable iff (!hresetn)
        $changed(in_place_output) |-> $past(s_r.settle_cnt) >= $past(s_r.settle_tmr);
    endproperty
    a_settle: assert property (p_settle) else $error("pin changed before settle");

    property p_cnt_edge;
        @(posedge hclk) disable iff (!hresetn)
        (!wr_cnt_zero && $rose(feedback_phase_a) && !feedback_phase_b && $stable(feedback_phase_b))
        |=> s_r.fb_cnt == $past(s_r.fb_cnt) + 32'h0000_0001;
    endproperty
    a_cnt_edge: assert property (p_cnt_edge) else $error("edge not counted up");

    property p_cnt_clear;
        @(posedge hclk) disable iff (!hresetn)
        wr_cnt_zero |=> (s_r.fb_cnt == 32'h0000_0000 || s_r.fb_cnt == 32'h0000_0001
            || s_r.fb_cnt == 32'hFFFF_FFFF);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

    property p_bypass;
        @(posedge hclk) disable iff (!hresetn)
        (s_r.thr != '0 && motor_speed <= s_r.thr && $stable(s_r.thr))
        |=> primary_torque_lpf_bypass && secondary_torque_lpf_bypass;
    endproperty
    a_bypass: assert property (p_bypass) else $error("filters not bypassed");

    property p_no_bypass;
        @(posedge hclk) disable iff (!hresetn)
        (s_r.thr == '0) ##1 (s_r.thr == '0) |-> !primary_torque_lpf_bypass;
    endproperty
    a_no_bypass: assert property (p_no_bypass) else $error("bypass with zero threshold");

    property p_snapshot;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[7:0] == servo_mon_pkg::OFS_IN_MONITOR)
        |=> hrdata == 32'($past(s_r.in_mon));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("monitor read not coherent");

    property p_in_place;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> s_r.out_mon[servo_mon_pkg::OUT_IN_PLACE] == $past(in_place_state);
    endproperty
    a_in_place: assert property (p_in_place) else $error("in-place monitor wrong");

    property p_prox_a;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> s_r.out_mon[servo_mon_pkg::OUT_PROX_A] == $past(proximity_a_state);
    endproperty
    a_prox_a: assert property (p_prox_a) else $error("proximity A monitor wrong");

    property p_prox_b;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> s_r.out_mon[servo_mon_pkg::OUT_PROX_B] == $past(proximity_b_state);
    endproperty
    a_prox_b: assert property (p_prox_b) else $error("proximity B monitor wrong");

    property p_healthy;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> s_r.out_mon[servo_mon_pkg::OUT_HEALTHY] == $past(healthy_state);
    endproperty
    a_healthy: assert property (p_healthy) else $error("healthy monitor wrong");

    property p_cnt_down;
        @(posedge hclk) disable iff (!hresetn)
        (!wr_cnt_zero && $fell(feedback_phase_a) && !feedback_phase_b
            && $stable(feedback_phase_b))
        |=> s_r.fb_cnt == $past(s_r.fb_cnt) - 32'h0000_0001;
    endproperty
    a_cnt_down: assert property (p_cnt_down) else $error("edge not counted down");

    sequence s_limit_steady;
        (s_r.db_tmr == '0 && !s_r.pol[servo_mon_pkg::IN_MINUS_LIMIT]
            && !s_r.wr_pend && minus_limit_input) [*2];
    endsequence
    property p_limit_mon;
        @(posedge hclk) disable iff (!hresetn)
        s_limit_steady |-> s_r.in_mon[servo_mon_pkg::IN_MINUS_LIMIT];
    endproperty
    a_limit_mon: assert property (p_limit_mon) else $error("limit monitor not set");

    sequence s_override_steady;
        (s_r.db_tmr == '0 && !s_r.pol[servo_mon_pkg::IN_OVERRIDE]
            && !s_r.wr_pend && speed_override_input) [*2];
    endsequence
    property p_override_mon;
        @(posedge hclk) disable iff (!hresetn)
        s_override_steady |-> s_r.in_mon[servo_mon_pkg::IN_OVERRIDE];
    endproperty
    a_override_mon: assert property (p_override_mon) else $error("override monitor not set");

endmodule

`default_nettype wire

//--- src/servo_mon_pkg.sv
package servo_mon_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FWD_GAIN = 8'h00;
    localparam logic [7:0] OFS_BYPASS_SPEED = 8'h04;
    localparam logic [7:0] OFS_IN_POLARITY = 8'h08;
    localparam logic [7:0] OFS_IN_DEBOUNCE = 8'h0C;
    localparam logic [7:0] OFS_OUT_SETTLE = 8'h10;
    localparam logic [7:0] OFS_OUT_SENSE = 8'h14;
    localparam logic [7:0] OFS_IN_MONITOR = 8'h18;
    localparam logic [7:0] OFS_OUT_MONITOR = 8'h1C;
    localparam logic [7:0] OFS_FB_COUNTER = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h2C;

    // Field widths
    localparam int GAIN_W = 14;
    localparam int SPEED_W = 14;
    localparam int TMR_W = 16;
    localparam int N_IN = 5;
    localparam int N_OUT = 4;
    localparam int N_EV = 4;

    // Gain in units of 0.0001, speed threshold in units of 0.001 per second
    localparam logic [GAIN_W-1:0] GAIN_MAX = 14'h2710;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 14'h2710;
    localparam logic [SPEED_W-1:0] SPEED_MAX = 14'h2710;
    localparam logic [SPEED_W-1:0] SPEED_RESET = 14'h0000;
    localparam logic [N_IN-1:0] POL_RESET = 5'h00;
    localparam logic [TMR_W-1:0] DEBOUNCE_RESET = 16'h0000;
    localparam logic [TMR_W-1:0] SETTLE_RESET = 16'h0000;
    localparam logic [N_OUT-1:0] SENSE_RESET = 4'h0;

    // Input monitor bit positions
    localparam int IN_HOLD = 0;
    localparam int IN_INTEG_OFF = 1;
    localparam int IN_JOG = 2;
    localparam int IN_OVERRIDE = 3;
    localparam int IN_MINUS_LIMIT = 4;

    // Output monitor bit positions
    localparam int OUT_IN_PLACE = 0;
    localparam int OUT_PROX_A = 1;
    localparam int OUT_PROX_B = 2;
    localparam int OUT_HEALTHY = 3;

    // Event bit positions
    localparam int EV_IN_CHANGE = 0;
    localparam int EV_OUT_CHANGE = 1;
    localparam int EV_CNT_WRAP = 2;
    localparam int EV_QUAD_ERR = 3;

endpackage

//--- test/host_io_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_io_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step_req,
    input wire logic step_dir,
    output logic feedback_phase_a,
    output logic feedback_phase_b
);
    logic [1:0] pos_r;
    // Quadrature position walks 00, 10, 11, 01 when stepping up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_r <= 2'h0;
        end else if (step_req) begin
            pos_r <= step_dir ? pos_r + 2'h1 : pos_r - 2'h1;
        end
    end
    assign feedback_phase_a = pos_r[0] ^ pos_r[1];
    assign feedback_phase_b = pos_r[1];
endmodule
`default_nettype wire

//--- test/servo_io_monitor_feedback_counter_test.sv
`timescale 1ns/10ps
`default_nettype none
module servo_io_monitor_feedback_counter_test;
    logic hclk, hresetn, hsel, hwrite, irq, step_req, step_dir;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic hreadyout, hresp, ffe, pbyp, sbyp, pha, phb;
    logic [4:0] in_raw;
    logic [3:0] out_lvl, pins;
    logic [13:0] speed, gain;
    int failures, checked, cycles;

    servo_io_monitor_feedback_counter dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .hold_input(in_raw[0]), .integrator_disable_input(in_raw[1]),
        .manual_move_input(in_raw[2]), .speed_override_input(in_raw[3]),
        .minus_limit_input(in_raw[4]), .in_place_state(out_lvl[0]),
        .proximity_a_state(out_lvl[1]), .proximity_b_state(out_lvl[2]),
        .healthy_state(out_lvl[3]), .in_place_output(pins[0]),
        .proximity_a_output(pins[1]), .proximity_b_output(pins[2]),
        .healthy_output(pins[3]), .feedback_phase_a(pha), .feedback_phase_b(phb),
        .motor_speed(speed), .forward_term_gain(gain), .feedforward_enable(ffe),
        .primary_torque_lpf_bypass(pbyp), .secondary_torque_lpf_bypass(sbyp)
    );
    host_io_model partner (
        .hclk(hclk), .hresetn(hresetn), .step_req(step_req), .step_dir(step_dir),
        .feedback_phase_a(pha), .feedback_phase_b(phb)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic step(input logic dir);
        @(posedge hclk);
        step_req <= 1'b1;
        step_dir <= dir;
        @(posedge hclk);
        step_req <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_gain;
        rdchk(servo_mon_pkg::OFS_FWD_GAIN, 32'h2710);
        check(32'(hresp), 32'h0);
        check(32'(gain), 32'h2710);
        check(32'(ffe), 32'h1);
        wr(servo_mon_pkg::OFS_FWD_GAIN, 32'h0);
        repeat (2) @(posedge hclk);
        check(32'(ffe), 32'h0);
        wr(servo_mon_pkg::OFS_FWD_GAIN, 32'h4E20);
        rdchk(servo_mon_pkg::OFS_FWD_GAIN, 32'h2710);
        check(32'(ffe), 32'h1);
    endtask
    task automatic t_bypass;
        repeat (3) @(posedge hclk);
        check(32'({pbyp, sbyp}), 32'h0);
        wr(servo_mon_pkg::OFS_BYPASS_SPEED, 32'h64);
        @(posedge hclk);
        speed <= 14'h0064;
        repeat (3) @(posedge hclk);
        check(32'({pbyp, sbyp}), 32'h3);
        speed <= 14'h0065;
        repeat (3) @(posedge hclk);
        check(32'({pbyp, sbyp}), 32'h0);
        wr(servo_mon_pkg::OFS_BYPASS_SPEED, 32'h4E20);
        rdchk(servo_mon_pkg::OFS_BYPASS_SPEED, 32'h2710);
        check(32'({pbyp, sbyp}), 32'h3);
    endtask
    task automatic t_counter;
        wr(servo_mon_pkg::OFS_FB_COUNTER, 32'h0);
        repeat (5) step(1'b1);
        rdchk(servo_mon_pkg::OFS_FB_COUNTER, 32'h5);
        repeat (8) step(1'b0);
        rdchk(servo_mon_pkg::OFS_FB_COUNTER, 32'hFFFFFFFD);
        wr(servo_mon_pkg::OFS_FB_COUNTER, 32'h7);
        rdchk(servo_mon_pkg::OFS_FB_COUNTER, 32'hFFFFFFFD);
        wr(servo_mon_pkg::OFS_FB_COUNTER, 32'h0);
        rdchk(servo_mon_pkg::OFS_FB_COUNTER, 32'h0);
    endtask
    task automatic t_inputs;
        logic [4:0] e;
        e = 5'h00;
        @(posedge hclk);
        in_raw <= 5'h1F;
        repeat (3) @(posedge hclk);
        rdchk(servo_mon_pkg::OFS_IN_MONITOR, 32'h1F);
        in_raw <= 5'h00;
        repeat (3) @(posedge hclk);
        wr(servo_mon_pkg::OFS_IN_DEBOUNCE, 32'h3);
        for (int i = 0; i < 5; i++) begin
            @(posedge hclk);
            in_raw[i] <= 1'b1;
            rdchk(servo_mon_pkg::OFS_IN_MONITOR, 32'(e));
            e[i] = 1'b1;
            repeat (10) @(posedge hclk);
            rdchk(servo_mon_pkg::OFS_IN_MONITOR, 32'(e));
        end
        wr(servo_mon_pkg::OFS_IN_POLARITY, 32'h5);
        repeat (10) @(posedge hclk);
        rdchk(servo_mon_pkg::OFS_IN_MONITOR, 32'h1A);
        @(posedge hclk);
        in_raw <= 5'h00;
        repeat (2) @(posedge hclk);
        in_raw <= 5'h1F;
        repeat (10) @(posedge hclk);
        rdchk(servo_mon_pkg::OFS_IN_MONITOR, 32'h1A);
    endtask
    task automatic t_outputs;
        @(posedge hclk);
        out_lvl <= 4'hA;
        repeat (5) @(posedge hclk);
        rdchk(servo_mon_pkg::OFS_OUT_MONITOR, 32'hA);
        check(32'(pins), 32'hA);
        wr(servo_mon_pkg::OFS_OUT_SENSE, 32'hF);
        repeat (3) @(posedge hclk);
        check(32'(pins), 32'h5);
        rdchk(servo_mon_pkg::OFS_OUT_MONITOR, 32'hA);
        wr(servo_mon_pkg::OFS_OUT_SETTLE, 32'h8);
        @(posedge hclk);
        out_lvl <= 4'h3;
        repeat (3) @(posedge hclk);
        check(32'(pins), 32'h5);
        repeat (15) @(posedge hclk);
        check(32'(pins), 32'hC);
        rdchk(servo_mon_pkg::OFS_OUT_MONITOR, 32'h3);
    endtask
    task automatic t_irq;
        wr(servo_mon_pkg::OFS_IRQ_CLEAR, 32'hF);
        rdchk(servo_mon_pkg::OFS_IRQ_STATUS, 32'h0);
        @(posedge hclk);
        in_raw[0] <= 1'b0;
        repeat (10) @(posedge hclk);
        rdchk(servo_mon_pkg::OFS_IRQ_STATUS, 32'h1);
        check(32'(irq), 32'h0);
        wr(servo_mon_pkg::OFS_IRQ_ENABLE, 32'h1);
        repeat (2) @(posedge hclk);
        check(32'(irq), 32'h1);
        wr(servo_mon_pkg::OFS_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge hclk);
        check(32'(irq), 32'h0);
        wr(servo_mon_pkg::OFS_IRQ_ENABLE, 32'h1);
        wr(servo_mon_pkg::OFS_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge hclk);
        check(32'(irq), 32'h0);
        rdchk(servo_mon_pkg::OFS_IRQ_STATUS, 32'h0);
        rdchk(8'h3C, 32'h0);
        wr(servo_mon_pkg::OFS_IN_MONITOR, 32'h0);
        rdchk(servo_mon_pkg::OFS_IN_MONITOR, 32'h1B);
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        in_raw = 5'h00;
        out_lvl = 4'h0;
        speed = 14'h0000;
        step_req = 1'b0;
        step_dir = 1'b0;
        failures = 0;
        checked = 0;
        cycles = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_gain();
        t_bypass();
        t_counter();
        t_inputs();
        t_outputs();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
